// ==== common/ldlc_pkg.sv ====
package ldlc_pkg;

  // shift word and latch geometry
  localparam int LDLC_WORD_W   = 25;
  localparam int LDLC_CHAN_W   = 24;
  localparam int LDLC_SEL_BIT  = 24;
  localparam int LDLC_GROUP_N  = 3;
  localparam int LDLC_GROUP_CH = 8;
  localparam int LDLC_BLUE_IDX = 2;

  // brightness fields of the control latch
  localparam int LDLC_LEVEL_W  = 7;
  localparam int LDLC_LEVEL_STEPS = 128;
  localparam int LDLC_LEVEL_MAX   = LDLC_LEVEL_STEPS - 1;
  localparam int LDLC_RED_LSB   = 0;
  localparam int LDLC_GREEN_LSB = 7;
  localparam int LDLC_BLUE_LSB  = 14;

  // fault detection select field
  localparam int LDLC_FAULT_LSB   = 21;
  localparam int LDLC_FAULT_W     = 3;
  localparam int LDLC_FAULT_SHORT = 2;
  localparam int LDLC_THRESH_W    = 2;

  // full scale sink current in microamps
  localparam int LDLC_CUR_W      = 16;
  localparam int LDLC_FULL_RG_UA = 35000;
  localparam int LDLC_FULL_B_UA  = 26200;

  // latch reset values
  localparam logic [LDLC_CHAN_W-1:0] LDLC_ONOFF_RST = 24'h000000;
  localparam logic [LDLC_CHAN_W-1:0] LDLC_CTRL_RST  = 24'h000000;

  // timing
  localparam int LDLC_REF_NS        = 50;
  localparam int LDLC_LATCH_HIGH_NS = 200;
  localparam int LDLC_LATCH_GAP_NS  = 200;
  localparam int LDLC_LATCH_HIGH_CYC = (LDLC_LATCH_HIGH_NS + LDLC_REF_NS - 1) / LDLC_REF_NS;
  localparam int LDLC_LATCH_GAP_CYC  = (LDLC_LATCH_GAP_NS + LDLC_REF_NS - 1) / LDLC_REF_NS;
  localparam int LDLC_LINK_HALF_CYC  = 4;
  localparam int LDLC_TMR_W          = 8;
  localparam int LDLC_BIT_W          = 5;

  // host frame states, gray along the path
  typedef enum logic [1:0] {
    LDLC_IDLE  = 2'b00,
    LDLC_SHIFT = 2'b01,
    LDLC_LATCH = 2'b11,
    LDLC_GAP   = 2'b10
  } ldlc_state_type;

endpackage

// ==== common/ldlc_link_if.sv ====
`timescale 1ns/1ns
interface ldlc_link_if;
  logic serial_clk;
  logic serial_data;
  logic latch_strobe;
  logic blank;
  logic serial_chain_out;

  modport device (
    input  serial_clk,
    input  serial_data,
    input  latch_strobe,
    input  blank,
    output serial_chain_out
  );

  modport host (
    output serial_clk,
    output serial_data,
    output latch_strobe,
    output blank,
    input  serial_chain_out
  );
endinterface

// ==== src/ldlc_sync.sv ====
`timescale 1ns/1ns
module ldlc_sync
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  // clock and synchronous reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // two stages; first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end
    else
    begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule // ldlc_sync

// ==== src/ldlc_device.sv ====
`timescale 1ns/1ns
module ldlc_device
  import ldlc_pkg::*;
#(
  parameter int FULL_SCALE_RG_UA = LDLC_FULL_RG_UA,
  parameter int FULL_SCALE_B_UA  = LDLC_FULL_B_UA
)
(
  // core clock and reset
  input  wire logic                     REF_CLK,
  input  wire logic                     RST_N,
  // serial link from the controller
  ldlc_link_if.device                   lnk,
  // per-channel sink enables
  output logic [LDLC_GROUP_CH-1:0]      RED_CHANNEL_SINK,
  output logic [LDLC_GROUP_CH-1:0]      GREEN_CHANNEL_SINK,
  output logic [LDLC_GROUP_CH-1:0]      BLUE_CHANNEL_SINK,
  // per-group brightness codes
  output logic [LDLC_LEVEL_W-1:0]       RED_GROUP_LEVEL,
  output logic [LDLC_LEVEL_W-1:0]       GREEN_GROUP_LEVEL,
  output logic [LDLC_LEVEL_W-1:0]       BLUE_GROUP_LEVEL,
  // per-group sink current in microamps
  output logic [LDLC_CUR_W-1:0]         RED_GROUP_CURRENT,
  output logic [LDLC_CUR_W-1:0]         GREEN_GROUP_CURRENT,
  output logic [LDLC_CUR_W-1:0]         BLUE_GROUP_CURRENT,
  // fault detection setup
  output logic [LDLC_FAULT_W-1:0]       FAULT_DETECT_SELECT,
  output logic [LDLC_THRESH_W-1:0]      FAULT_THRESHOLD_STEP,
  output logic                          OPEN_FAULT_DETECT,
  output logic                          SHORT_FAULT_DETECT
);

  localparam int LSB_TAB [LDLC_GROUP_N] = '{LDLC_RED_LSB, LDLC_GREEN_LSB, LDLC_BLUE_LSB};

  // link domain
  logic [LDLC_WORD_W-1:0]  serial_shift_word_reg;

  // core domain
  logic [1:0]              pin_sync;
  logic                    strobe_sync;
  logic                    blank_sync;
  logic                    strobe_prev_reg;
  logic                    strobe_rise;
  logic                    load_onoff;
  logic                    load_ctrl;
  logic [LDLC_CHAN_W-1:0]  channel_enable_latch_reg;
  logic [LDLC_CHAN_W-1:0]  channel_enable_latch_next;
  logic [LDLC_CHAN_W-1:0]  group_brightness_latch_reg;
  logic [LDLC_CHAN_W-1:0]  group_brightness_latch_next;
  logic [LDLC_CHAN_W-1:0]  sink_enable_reg;
  logic [LDLC_CHAN_W-1:0]  sink_enable_next;
  logic [LDLC_FAULT_W-1:0] fault_sel_next;
  logic [LDLC_FAULT_W-1:0] fault_sel_reg;

  logic [LDLC_LEVEL_W-1:0] level_next [LDLC_GROUP_N];
  logic [LDLC_LEVEL_W-1:0] level_reg  [LDLC_GROUP_N];
  logic [LDLC_CUR_W-1:0]   current_next [LDLC_GROUP_N];
  logic [LDLC_CUR_W-1:0]   current_reg  [LDLC_GROUP_N];

  // link side shift register, no reset: it has no power-on value
  // sample in, shift up
  always_ff @(posedge lnk.serial_clk)
  begin
    serial_shift_word_reg <= {serial_shift_word_reg[LDLC_WORD_W-2:0], lnk.serial_data};
  end

  assign lnk.serial_chain_out = serial_shift_word_reg[LDLC_SEL_BIT];

  // strobe and blank cross into the core clock; blank resets high
  ldlc_sync #(
    .WIDTH     (2),
    .RESET_VAL (2'h1)
  ) u_pin_sync (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .din   ({lnk.latch_strobe, lnk.blank}),
    .dout  (pin_sync)
  );

  assign strobe_sync = pin_sync[1];
  assign blank_sync  = pin_sync[0];

  // strobe edge detect on the synchronised copy
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      strobe_prev_reg <= 1'b0;
    else
      strobe_prev_reg <= strobe_sync;
  end

  // the shift word is read here only after the strobe rose; the serial
  // clock is idle by then, so the word is quiet while it crosses
  // transfer on strobe rise
  assign strobe_rise = strobe_sync & ~strobe_prev_reg;
  assign load_onoff  = strobe_rise & ~serial_shift_word_reg[LDLC_SEL_BIT];
  assign load_ctrl   = strobe_rise &  serial_shift_word_reg[LDLC_SEL_BIT];

  assign channel_enable_latch_next   = load_onoff ? serial_shift_word_reg[LDLC_CHAN_W-1:0]
                                                  : channel_enable_latch_reg;
  assign group_brightness_latch_next = load_ctrl  ? serial_shift_word_reg[LDLC_CHAN_W-1:0]
                                                  : group_brightness_latch_reg;

  assign sink_enable_next = channel_enable_latch_next & ~{LDLC_CHAN_W{blank_sync}};

  assign fault_sel_next = group_brightness_latch_next[LDLC_FAULT_LSB +: LDLC_FAULT_W];

  // per-group level and scaled current, built from the next latch value
  // so a new code shows in the same edge that stores it
  generate
    for (genvar g = 0; g < LDLC_GROUP_N; g++)
    begin : g_group
      localparam int FULL_UA = (g == LDLC_BLUE_IDX) ? FULL_SCALE_B_UA : FULL_SCALE_RG_UA;
      logic [LDLC_CUR_W+LDLC_LEVEL_W-1:0] product;
      assign level_next[g] = group_brightness_latch_next[LSB_TAB[g] +: LDLC_LEVEL_W];
      assign product = (LDLC_CUR_W+LDLC_LEVEL_W)'(level_next[g]) *
                       (LDLC_CUR_W+LDLC_LEVEL_W)'(FULL_UA);
      assign current_next[g] = LDLC_CUR_W'(product / (LDLC_CUR_W+LDLC_LEVEL_W)'(LDLC_LEVEL_MAX));
    end
  endgenerate

  // latches; reset clears both so sinks start off
  // no usable default value
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      channel_enable_latch_reg   <= LDLC_ONOFF_RST;
      group_brightness_latch_reg <= LDLC_CTRL_RST;
    end
    else
    begin
      channel_enable_latch_reg   <= channel_enable_latch_next;
      group_brightness_latch_reg <= group_brightness_latch_next;
    end
  end

  // output registers for enables and fault setup
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      sink_enable_reg <= '0;
      fault_sel_reg   <= LDLC_CTRL_RST[LDLC_FAULT_LSB +: LDLC_FAULT_W];
    end
    else
    begin
      sink_enable_reg <= sink_enable_next;
      fault_sel_reg   <= fault_sel_next;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    for (int g = 0; g < LDLC_GROUP_N; g++)
    begin
      if (!RST_N)
      begin
        level_reg[g]   <= '0;
        current_reg[g] <= '0;
      end
      else
      begin
        level_reg[g]   <= level_next[g];
        current_reg[g] <= current_next[g];
      end
    end
  end

  // channel enables split by color group
  assign RED_CHANNEL_SINK   = sink_enable_reg[0*LDLC_GROUP_CH +: LDLC_GROUP_CH];
  assign GREEN_CHANNEL_SINK = sink_enable_reg[1*LDLC_GROUP_CH +: LDLC_GROUP_CH];
  assign BLUE_CHANNEL_SINK  = sink_enable_reg[2*LDLC_GROUP_CH +: LDLC_GROUP_CH];

  // brightness codes and currents to the analog sinks
  assign RED_GROUP_LEVEL     = level_reg[0];
  assign GREEN_GROUP_LEVEL   = level_reg[1];
  assign BLUE_GROUP_LEVEL    = level_reg[LDLC_BLUE_IDX];
  assign RED_GROUP_CURRENT   = current_reg[0];
  assign GREEN_GROUP_CURRENT = current_reg[1];
  assign BLUE_GROUP_CURRENT  = current_reg[LDLC_BLUE_IDX];

  // fault setup: top select bit picks short over open
  assign FAULT_DETECT_SELECT  = fault_sel_reg;
  assign FAULT_THRESHOLD_STEP = fault_sel_reg[LDLC_THRESH_W-1:0];
  assign OPEN_FAULT_DETECT    = ~fault_sel_reg[LDLC_FAULT_SHORT];
  assign SHORT_FAULT_DETECT   =  fault_sel_reg[LDLC_FAULT_SHORT];

endmodule // ldlc_device

// ==== src/ldlc_host.sv ====
`timescale 1ns/1ns
module ldlc_host
  import ldlc_pkg::*;
#(
  parameter int LINK_HALF = LDLC_LINK_HALF_CYC
)
(
  // clock and reset
  input  wire logic                   REF_CLK,
  input  wire logic                   RST_N,
  // word request
  input  wire logic                   SEND_VALID,
  input  wire logic [LDLC_WORD_W-1:0] SEND_WORD,
  output logic                        SEND_READY,
  // channel setup
  input  wire logic [LDLC_CHAN_W-1:0] UNUSED_CHANNELS,
  input  wire logic                   BLANK_REQUEST,
  // readback of the word shifted out
  output logic [LDLC_WORD_W-1:0]      READBACK_WORD,
  output logic                        READBACK_VALID,
  // link to the device
  ldlc_link_if.host                   lnk
);

  localparam int DIV_W = $clog2(LINK_HALF + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINK_HALF - 1);
  localparam logic [LDLC_TMR_W-1:0] HIGH_LAST = LDLC_TMR_W'(LDLC_LATCH_HIGH_CYC - 1);
  localparam logic [LDLC_TMR_W-1:0] GAP_LAST  = LDLC_TMR_W'(LDLC_LATCH_GAP_CYC - 1);
  localparam logic [LDLC_BIT_W-1:0] BIT_LAST  = LDLC_BIT_W'(LDLC_WORD_W - 1);

  ldlc_state_type          state_reg, state_next;
  logic [DIV_W-1:0]        div_cnt_reg;
  logic                    phase_reg;
  logic                    phase_next;
  logic                    div_tick;
  logic                    rise_evt;
  logic                    fall_evt;
  logic                    chain_sync;
  logic                    accept;
  logic                    tmr_done;
  logic [LDLC_WORD_W-1:0]  word_masked;
  logic [LDLC_WORD_W-1:0]  tx_reg;
  logic [LDLC_WORD_W-1:0]  rx_reg;
  logic [LDLC_BIT_W-1:0]   bit_cnt_reg;
  logic [LDLC_TMR_W-1:0]   tmr_reg;
  logic                    sclk_reg;
  logic                    data_reg;
  logic                    strobe_reg;
  logic                    blank_reg;
  logic                    sel_reg;
  logic                    onoff_done_reg;
  logic                    ctrl_done_reg;
  logic                    rb_valid_reg;

  // free-running divider; the pin only toggles inside a frame
  assign div_tick   = (div_cnt_reg == DIV_LAST);
  assign phase_next = div_tick ? ~phase_reg : phase_reg;
  assign rise_evt   = div_tick & ~phase_reg;
  assign fall_evt   = div_tick &  phase_reg;

  // readback pin crosses in over two stages
  ldlc_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'h0)
  ) u_chain_sync (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .din   (lnk.serial_chain_out),
    .dout  (chain_sync)
  );

  assign word_masked = SEND_WORD[LDLC_SEL_BIT] ? SEND_WORD
                     : {1'b0, SEND_WORD[LDLC_CHAN_W-1:0] & ~UNUSED_CHANNELS};

  // words start only on a falling phase, so data leads the first rise
  assign SEND_READY = (state_reg == LDLC_IDLE) & fall_evt;
  assign accept     = SEND_READY & SEND_VALID;
  assign tmr_done   = (state_reg == LDLC_LATCH) ? (tmr_reg == HIGH_LAST) : (tmr_reg == GAP_LAST);

  // frame sequencing
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      LDLC_IDLE:  if (accept) state_next = LDLC_SHIFT;
      LDLC_SHIFT: if (fall_evt && bit_cnt_reg == BIT_LAST) state_next = LDLC_LATCH;
      LDLC_LATCH: if (tmr_done) state_next = LDLC_GAP;
      LDLC_GAP:   if (tmr_done) state_next = LDLC_IDLE;
      default:    state_next = LDLC_IDLE;
    endcase
  end

  // divider, state and pins
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      state_reg   <= LDLC_IDLE;
      div_cnt_reg <= '0;
      phase_reg   <= 1'b0;
      sclk_reg    <= 1'b0;
      strobe_reg  <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      div_cnt_reg <= div_tick ? '0 : div_cnt_reg + 1'b1;
      phase_reg   <= phase_next;
      sclk_reg    <= phase_next & (state_next == LDLC_SHIFT);
      strobe_reg  <= (state_next == LDLC_LATCH);
    end
  end

  // serial data out, first bit is the select bit
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      tx_reg      <= '0;
      data_reg    <= 1'b0;
      bit_cnt_reg <= '0;
      sel_reg     <= 1'b0;
    end
    else if (accept)
    begin
      tx_reg      <= word_masked;
      data_reg    <= word_masked[LDLC_SEL_BIT];
      bit_cnt_reg <= '0;
      sel_reg     <= word_masked[LDLC_SEL_BIT];
    end
    else if (state_reg == LDLC_SHIFT && fall_evt)
    begin
      tx_reg      <= {tx_reg[LDLC_WORD_W-2:0], 1'b0};
      data_reg    <= tx_reg[LDLC_WORD_W-2];
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
  end

  // readback sampled just before each rise, oldest bit first
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      rx_reg       <= '0;
      rb_valid_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == LDLC_SHIFT && rise_evt)
        rx_reg <= {rx_reg[LDLC_WORD_W-2:0], chain_sync};
      rb_valid_reg <= (state_reg == LDLC_SHIFT) & (state_next == LDLC_LATCH);
    end
  end

  // strobe and gap timer
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N || state_next != state_reg)
      tmr_reg <= '0;
    else
      tmr_reg <= tmr_reg + 1'b1;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      onoff_done_reg <= 1'b0;
      ctrl_done_reg  <= 1'b0;
      blank_reg      <= 1'b1;
    end
    else
    begin
      if (state_reg == LDLC_SHIFT && state_next == LDLC_LATCH)
      begin
        onoff_done_reg <= onoff_done_reg | ~sel_reg;
        ctrl_done_reg  <= ctrl_done_reg | sel_reg;
      end
      blank_reg <= BLANK_REQUEST | ~(onoff_done_reg & ctrl_done_reg);
    end
  end

  assign lnk.serial_clk   = sclk_reg;
  assign lnk.serial_data  = data_reg;
  assign lnk.latch_strobe = strobe_reg;
  assign lnk.blank        = blank_reg;
  assign READBACK_WORD    = rx_reg;
  assign READBACK_VALID   = rb_valid_reg;

endmodule // ldlc_host

// ==== tb/ldlc_link_properties.sv ====
`timescale 1ns/1ns
module ldlc_link_properties
  import ldlc_pkg::*;
(
  // core clock and reset
  input wire logic                    REF_CLK,
  input wire logic                    RST_N,
  // link wires
  input wire logic                    serial_clk,
  input wire logic                    serial_data,
  input wire logic                    latch_strobe,
  input wire logic                    blank,
  input wire logic                    serial_chain_out,
  // device outputs
  input wire logic [LDLC_GROUP_CH-1:0] RED_CHANNEL_SINK,
  input wire logic [LDLC_GROUP_CH-1:0] GREEN_CHANNEL_SINK,
  input wire logic [LDLC_GROUP_CH-1:0] BLUE_CHANNEL_SINK,
  input wire logic [LDLC_LEVEL_W-1:0]  RED_GROUP_LEVEL,
  input wire logic [LDLC_LEVEL_W-1:0]  BLUE_GROUP_LEVEL,
  input wire logic [LDLC_CUR_W-1:0]    RED_GROUP_CURRENT,
  input wire logic [LDLC_CUR_W-1:0]    BLUE_GROUP_CURRENT,
  input wire logic [LDLC_FAULT_W-1:0]  FAULT_DETECT_SELECT,
  input wire logic                     OPEN_FAULT_DETECT,
  input wire logic                     SHORT_FAULT_DETECT
);
  // link rises seen; the shift word has no reset, so only a count makes it defined
  logic [5:0] rises = 6'h00;
  logic [3:0] strobe_age;
  wire        sinks_on = |{RED_CHANNEL_SINK, GREEN_CHANNEL_SINK, BLUE_CHANNEL_SINK};

  // saturating rise counter in the link domain
  always_ff @(posedge serial_clk)
    if (rises != 6'h1E) rises <= rises + 6'h01;

  // cycles since the strobe was last high
  always_ff @(posedge REF_CLK)
    if (!RST_N || latch_strobe) strobe_age <= 4'h0;
    else if (strobe_age != 4'hF) strobe_age <= strobe_age + 4'h1;

  strobe_clk_idle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    latch_strobe |-> !serial_clk) else $error("link clock moved while strobe high");
  strobe_width_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $rose(latch_strobe) |-> latch_strobe [*4] ##1 !latch_strobe) else $error("strobe width wrong");
  blank_all_off_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    blank [*4] |-> !sinks_on) else $error("channel on while blanked");
  chain_delay_a: assert property (@(posedge serial_clk) disable iff (!RST_N)
    rises >= 6'h19 |-> serial_chain_out == $past(serial_data, 25)) else $error("chain out not 25 bits late");
  red_current_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $stable(RED_GROUP_LEVEL) |-> RED_GROUP_CURRENT == 16'(int'(RED_GROUP_LEVEL) * LDLC_FULL_RG_UA / LDLC_LEVEL_MAX))
    else $error("red current off");
  blue_current_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $stable(BLUE_GROUP_LEVEL) |-> BLUE_GROUP_CURRENT == 16'(int'(BLUE_GROUP_LEVEL) * LDLC_FULL_B_UA / LDLC_LEVEL_MAX))
    else $error("blue current off");
  level_on_strobe_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !$stable(RED_GROUP_LEVEL) |-> strobe_age <= 4'h3) else $error("level changed without strobe");
  fault_kind_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SHORT_FAULT_DETECT == FAULT_DETECT_SELECT[2] && OPEN_FAULT_DETECT == !FAULT_DETECT_SELECT[2])
    else $error("fault kind wrong");
  fault_on_strobe_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $changed(FAULT_DETECT_SELECT) |-> strobe_age <= 4'h3) else $error("fault select changed without strobe");

  // main scenarios reached
  strobe_seen_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) $rose(latch_strobe));
  short_seen_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) SHORT_FAULT_DETECT);
  lit_seen_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) !blank && sinks_on);
endmodule // ldlc_link_properties

// ==== tb/ldlc_bench.sv ====
`timescale 1ns/1ns
module ldlc_bench;
  import ldlc_pkg::*;
  logic                   ref_clk, rst_n, send_valid, send_ready, blank_request, readback_valid, have_prev;
  logic [LDLC_WORD_W-1:0] send_word, readback_word, prev_word;
  logic [LDLC_CHAN_W-1:0] unused_channels, on_bits, ctrl_bits;
  logic [7:0]             red_sink, green_sink, blue_sink;
  logic [6:0]             red_level, green_level, blue_level;
  logic [15:0]            red_cur, green_cur, blue_cur;
  logic [2:0]             fault_sel;
  logic [1:0]             thresh_step;
  logic                   open_det, short_det;
  int                     n_mismatch, comparisons, cycles;

  ldlc_link_if link_if ();

  ldlc_host ldlc_host_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .SEND_VALID(send_valid), .SEND_WORD(send_word),
    .SEND_READY(send_ready), .UNUSED_CHANNELS(unused_channels), .BLANK_REQUEST(blank_request),
    .READBACK_WORD(readback_word), .READBACK_VALID(readback_valid), .lnk(link_if));

  ldlc_device ldlc_device_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .lnk(link_if),
    .RED_CHANNEL_SINK(red_sink), .GREEN_CHANNEL_SINK(green_sink), .BLUE_CHANNEL_SINK(blue_sink),
    .RED_GROUP_LEVEL(red_level), .GREEN_GROUP_LEVEL(green_level), .BLUE_GROUP_LEVEL(blue_level),
    .RED_GROUP_CURRENT(red_cur), .GREEN_GROUP_CURRENT(green_cur), .BLUE_GROUP_CURRENT(blue_cur),
    .FAULT_DETECT_SELECT(fault_sel), .FAULT_THRESHOLD_STEP(thresh_step),
    .OPEN_FAULT_DETECT(open_det), .SHORT_FAULT_DETECT(short_det));

  ldlc_link_properties ldlc_link_properties_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
    .serial_clk(link_if.serial_clk), .serial_data(link_if.serial_data), .latch_strobe(link_if.latch_strobe),
    .blank(link_if.blank), .serial_chain_out(link_if.serial_chain_out), .RED_CHANNEL_SINK(red_sink),
    .GREEN_CHANNEL_SINK(green_sink), .BLUE_CHANNEL_SINK(blue_sink), .RED_GROUP_LEVEL(red_level),
    .BLUE_GROUP_LEVEL(blue_level), .RED_GROUP_CURRENT(red_cur), .BLUE_GROUP_CURRENT(blue_cur),
    .FAULT_DETECT_SELECT(fault_sel), .OPEN_FAULT_DETECT(open_det), .SHORT_FAULT_DETECT(short_det));

  // core clock, 50 ns
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one frame through the host; called just after an edge, returns likewise
  task automatic send(input logic [LDLC_WORD_W-1:0] w);
    int i;
    send_word  = w;
    send_valid = 1'b1;
    for (i = 0; i < 100 && send_ready !== 1'b1; i++)
    begin
      @(posedge ref_clk);
      #2;
    end
    @(posedge ref_clk);
    #2;
    send_valid = 1'b0;
    for (i = 0; i < 400 && readback_valid !== 1'b1; i++)
    begin
      @(posedge ref_clk);
      #2;
    end
    chk({31'h0, readback_valid}, 32'h1);
    // readback shows the previous word, select bit first
    if (have_prev) chk({7'h0, readback_word}, {7'h0, prev_word});
    if (!w[LDLC_SEL_BIT]) w[LDLC_CHAN_W-1:0] = w[LDLC_CHAN_W-1:0] & ~unused_channels;
    prev_word = w;
    have_prev = 1'b1;
    // strobe, sync lag and gap all fit in this wait
    repeat (24) @(posedge ref_clk);
    #2;
  endtask

  // compare every device output against the latched values
  task automatic check_out(input logic [23:0] on, input logic [23:0] ctrl, input logic blanked);
    chk({8'h0, blue_sink, green_sink, red_sink}, blanked ? 32'h0 : {8'h0, on});
    chk({11'h0, blue_level, green_level, red_level}, {11'h0, ctrl[20:0]});
    chk(red_cur, int'(ctrl[6:0]) * LDLC_FULL_RG_UA / LDLC_LEVEL_MAX);
    chk(green_cur, int'(ctrl[13:7]) * LDLC_FULL_RG_UA / LDLC_LEVEL_MAX);
    chk(blue_cur, int'(ctrl[20:14]) * LDLC_FULL_B_UA / LDLC_LEVEL_MAX);
    chk({thresh_step, fault_sel, open_det, short_det}, {ctrl[22:21], ctrl[23:21], !ctrl[23], ctrl[23]});
    chk({31'h0, link_if.blank}, {31'h0, blanked});
  endtask

  // hang guard, well above the ten frames sent
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    send_valid = 1'b0;
    send_word = '0;
    unused_channels = '0;
    blank_request = 1'b0;
    have_prev = 1'b0;
    prev_word = '0;
    n_mismatch = 0;
    comparisons = 0;
    cycles = 0;
    repeat (6) @(posedge ref_clk);
    #2;
    rst_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #2;
    check_out(24'h0, 24'h0, 1'b1);
    // on-off alone keeps outputs blanked
    on_bits = 24'hA5C3F0;
    send({1'b0, on_bits});
    check_out(on_bits, 24'h0, 1'b1);
    // every detect code, levels spanning both ends of the range
    for (int c = 0; c < 8; c++)
    begin
      ctrl_bits = {3'(c), 7'(c * 11 + 1), 7'h7F - 7'(c), 7'(c * 18)};
      send({1'b1, ctrl_bits});
      check_out(on_bits, ctrl_bits, 1'b0);
    end
    // unwired channels are cleared by the host
    unused_channels = 24'h00000F;
    send({1'b0, 24'hFFFFFF});
    on_bits = 24'hFFFFF0;
    check_out(on_bits, ctrl_bits, 1'b0);
    // blanking overrides and then releases
    blank_request = 1'b1;
    repeat (8) @(posedge ref_clk);
    #2;
    check_out(on_bits, ctrl_bits, 1'b1);
    blank_request = 1'b0;
    repeat (8) @(posedge ref_clk);
    #2;
    check_out(on_bits, ctrl_bits, 1'b0);
    stop_test();
  end
endmodule // ldlc_bench
